// ==== hw/rrsb_params.svh ====
// Constants for the rotate-right and subtract-with-borrow datapath
`ifndef RRSB_PARAMS_SVH
`define RRSB_PARAMS_SVH
`define RRSB_DATA_W    8
`define RRSB_LSB       0
`define RRSB_NIB_W     4
`define RRSB_ACC_RST   8'h00
`define RRSB_FLAG_RST  1'b0
`endif

// ==== hw/rrsb_pkg.sv ====
// Types for the rotate-right and subtract-with-borrow datapath
package rrsb_pkg;
	typedef enum logic [2:0] {
		OP_IDLE                           = 3'b000,
		OP_ROTATE_RIGHT_MEM               = 3'b001,
		OP_ROTATE_RIGHT_TO_WORK           = 3'b010,
		OP_ROTATE_RIGHT_THRU_FLAG         = 3'b011,
		OP_ROTATE_RIGHT_THRU_FLAG_TO_WORK = 3'b100,
		OP_SUBTRACT_WITH_BORROW_MEM       = 3'b101,
		OP_SUBTRACT_WITH_BORROW_IMM       = 3'b110
	} rrsb_op_e;

	typedef struct packed {
		logic signed_wrap_flag;
		logic zero_flag;
		logic half_carry_flag;
		logic carry_flag;
		logic extended_sign_flag;
		logic chained_null_flag;
	} rrsb_flags_s;
endpackage

// ==== hw/rrsb_if.sv ====
// Link between the core registers and the combinational datapath
`timescale 1ns/10ps
interface rrsb_if #(parameter int W = 8);
	rrsb_pkg::rrsb_op_e    op;
	logic [W-1:0]          operand;
	logic [W-1:0]          work;
	rrsb_pkg::rrsb_flags_s flags_in;
	logic [W-1:0]          result;
	rrsb_pkg::rrsb_flags_s flags_out;
	logic                  to_mem;
	logic                  to_work;

	modport core (output op, operand, work, flags_in, input result, flags_out, to_mem, to_work);
	modport alu  (input op, operand, work, flags_in, output result, flags_out, to_mem, to_work);
endinterface

// ==== hw/rrsb_alu.sv ====
// Combinational rotate and subtract-with-borrow unit
`timescale 1ns/10ps
`include "rrsb_params.svh"
module rrsb_alu #(
	parameter int W = `RRSB_DATA_W
) (
	// Datapath link
	rrsb_if.alu bus
);
	localparam int NW = `RRSB_NIB_W;

	function automatic logic [W-1:0] rotate_right(input logic [W-1:0] v, input logic fill);
		rotate_right = {fill, v[W-1:1]};
	endfunction

	logic [W:0]  diff;
	logic [NW:0] low_diff;
	logic        borrow_in;

	always_comb begin
		borrow_in = ~bus.flags_in.carry_flag;
		diff      = {1'b0, bus.work} - {1'b0, bus.operand} - {{W{1'b0}}, borrow_in};
		low_diff  = {1'b0, bus.work[NW-1:0]} - {1'b0, bus.operand[NW-1:0]}
			- {{NW{1'b0}}, borrow_in};
		bus.result    = bus.work;
		bus.flags_out = bus.flags_in;
		bus.to_mem    = 1'b0;
		bus.to_work   = 1'b0;
		unique case (bus.op)
			rrsb_pkg::OP_IDLE: begin
			end
			rrsb_pkg::OP_ROTATE_RIGHT_MEM: begin
				bus.result = rotate_right(bus.operand, bus.operand[`RRSB_LSB]);
				bus.to_mem = 1'b1;
			end
			rrsb_pkg::OP_ROTATE_RIGHT_TO_WORK: begin
				bus.result  = rotate_right(bus.operand, bus.operand[`RRSB_LSB]);
				bus.to_work = 1'b1;
			end
			rrsb_pkg::OP_ROTATE_RIGHT_THRU_FLAG: begin
				bus.result = rotate_right(bus.operand, bus.flags_in.carry_flag);
				bus.flags_out.carry_flag = bus.operand[`RRSB_LSB];
				bus.to_mem = 1'b1;
			end
			rrsb_pkg::OP_ROTATE_RIGHT_THRU_FLAG_TO_WORK: begin
				bus.result = rotate_right(bus.operand, bus.flags_in.carry_flag);
				bus.flags_out.carry_flag = bus.operand[`RRSB_LSB];
				bus.to_work = 1'b1;
			end
			rrsb_pkg::OP_SUBTRACT_WITH_BORROW_MEM,
			rrsb_pkg::OP_SUBTRACT_WITH_BORROW_IMM: begin
				bus.result  = diff[W-1:0];
				bus.to_work = 1'b1;
				// Borrow out clears carry, no borrow sets it
				bus.flags_out.carry_flag = ~diff[W];
				bus.flags_out.half_carry_flag = ~low_diff[NW];
				bus.flags_out.zero_flag = (diff[W-1:0] == '0);
				bus.flags_out.signed_wrap_flag = (bus.work[W-1] ^ bus.operand[W-1])
					& (bus.work[W-1] ^ diff[W-1]);
				bus.flags_out.extended_sign_flag = diff[W-1] ^ bus.flags_out.signed_wrap_flag;
				// Zero across a chained multi-byte subtract
				bus.flags_out.chained_null_flag = bus.flags_out.zero_flag
					& bus.flags_in.chained_null_flag;
			end
			default: begin
			end
		endcase
	end
endmodule

// ==== hw/rrsb_top.sv ====
// Rotate-right and subtract-with-borrow execution datapath
`timescale 1ns/10ps
`include "rrsb_params.svh"
module rrsb_top #(
	parameter int W = `RRSB_DATA_W
) (
	// Clock and reset
	input  wire logic                  i_core_clk,
	input  wire logic                  i_reset,
	// Instruction request
	input  wire logic                  i_valid,
	input  wire rrsb_pkg::rrsb_op_e    i_op,
	input  wire logic [W-1:0]          i_mem_data,
	input  wire logic [W-1:0]          i_imm,
	// Memory write-back
	output logic                       o_mem_wr,
	output logic [W-1:0]               o_mem_wr_data,
	// Core state
	output logic                       o_done,
	output logic [W-1:0]               o_work_register,
	output rrsb_pkg::rrsb_flags_s      o_flags
);
	rrsb_if #(.W(W)) dp ();

	rrsb_alu #(.W(W)) u_alu (
		.bus (dp)
	);

	logic [W-1:0]          work_register;
	rrsb_pkg::rrsb_flags_s flags;
	logic                  done;
	logic                  mem_wr;
	logic [W-1:0]          mem_wr_data;

	always_comb begin
		dp.op       = i_valid ? i_op : rrsb_pkg::OP_IDLE;
		dp.operand  = (i_op == rrsb_pkg::OP_SUBTRACT_WITH_BORROW_IMM) ? i_imm : i_mem_data;
		dp.work     = work_register;
		dp.flags_in = flags;
	end

	// Work register load
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			work_register <= `RRSB_ACC_RST;
		end else if (dp.to_work) begin
			work_register <= dp.result;
		end
	end

	// Status flags
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			flags <= '{default: `RRSB_FLAG_RST};
		end else begin
			flags <= dp.flags_out;
		end
	end

	// Memory write-back, only for the in-place forms
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			mem_wr      <= 1'b0;
			mem_wr_data <= `RRSB_ACC_RST;
		end else begin
			mem_wr <= dp.to_mem;
			if (dp.to_mem) begin
				mem_wr_data <= dp.result;
			end
		end
	end

	// Completion strobe
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			done <= 1'b0;
		end else begin
			done <= i_valid && (i_op != rrsb_pkg::OP_IDLE);
		end
	end

	assign o_mem_wr        = mem_wr;
	assign o_mem_wr_data   = mem_wr_data;
	assign o_done          = done;
	assign o_work_register = work_register;
	assign o_flags         = flags;

	// Checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	localparam int NW = `RRSB_NIB_W;

	logic [W-1:0]          h_mem;
	logic [W-1:0]          h_imm;
	logic [W-1:0]          h_work;
	rrsb_pkg::rrsb_flags_s h_flags;
	logic [W:0]            h_diff;
	rrsb_pkg::rrsb_op_e    h_op;
	logic [W-1:0]          h_src;
	logic [NW:0]           h_low;

	always_ff @(posedge i_core_clk) begin
		h_mem   <= i_mem_data;
		h_imm   <= i_imm;
		h_work  <= work_register;
		h_flags <= flags;
		h_op    <= i_op;
	end

	always_comb begin
		// Operand chosen by the op of the request cycle, not the current one
		h_src  = (h_op == rrsb_pkg::OP_SUBTRACT_WITH_BORROW_IMM) ? h_imm : h_mem;
		h_diff = {1'b0, h_work} - {1'b0, h_src} - {{W{1'b0}}, ~h_flags.carry_flag};
		h_low  = {1'b0, h_work[NW-1:0]} - {1'b0, h_src[NW-1:0]}
			- {{NW{1'b0}}, ~h_flags.carry_flag};
	end

	sequence s_req(rrsb_pkg::rrsb_op_e op);
		i_valid && i_op == op;
	endsequence

	sequence s_sub;
		s_req(rrsb_pkg::OP_SUBTRACT_WITH_BORROW_MEM)
			or s_req(rrsb_pkg::OP_SUBTRACT_WITH_BORROW_IMM);
	endsequence

	sequence s_rotc;
		s_req(rrsb_pkg::OP_ROTATE_RIGHT_THRU_FLAG)
			or s_req(rrsb_pkg::OP_ROTATE_RIGHT_THRU_FLAG_TO_WORK);
	endsequence

	property p_rot_mem;
		s_req(rrsb_pkg::OP_ROTATE_RIGHT_MEM) |=> o_mem_wr && o_done
			&& o_mem_wr_data == {h_mem[0], h_mem[W-1:1]} && o_flags == h_flags
			&& o_work_register == h_work;
	endproperty
	a_rot_mem: assert property (p_rot_mem) else $error("memory rotate wrong");

	property p_rot_work;
		s_req(rrsb_pkg::OP_ROTATE_RIGHT_TO_WORK) |=> !o_mem_wr
			&& o_work_register == {h_mem[0], h_mem[W-1:1]} && o_flags == h_flags;
	endproperty
	a_rot_work: assert property (p_rot_work) else $error("work rotate wrong");

	property p_rotc_mem;
		s_req(rrsb_pkg::OP_ROTATE_RIGHT_THRU_FLAG) |=> o_mem_wr
			&& o_mem_wr_data == {h_flags.carry_flag, h_mem[W-1:1]}
			&& o_flags.carry_flag == h_mem[0] && o_flags.zero_flag == h_flags.zero_flag
			&& o_work_register == h_work;
	endproperty
	a_rotc_mem: assert property (p_rotc_mem) else $error("carry rotate to memory wrong");

	property p_rotc_work;
		s_req(rrsb_pkg::OP_ROTATE_RIGHT_THRU_FLAG_TO_WORK) |=> !o_mem_wr
			&& o_work_register == {h_flags.carry_flag, h_mem[W-1:1]}
			&& o_flags.carry_flag == h_mem[0];
	endproperty
	a_rotc_work: assert property (p_rotc_work) else $error("carry rotate to work wrong");

	property p_sub_mem;
		s_req(rrsb_pkg::OP_SUBTRACT_WITH_BORROW_MEM) |=> !o_mem_wr
			&& o_work_register == h_diff[W-1:0];
	endproperty
	a_sub_mem: assert property (p_sub_mem) else $error("memory subtract wrong");

	property p_sub_imm;
		s_req(rrsb_pkg::OP_SUBTRACT_WITH_BORROW_IMM)
			|=> !o_mem_wr && o_work_register == h_diff[W-1:0];
	endproperty
	a_sub_imm: assert property (p_sub_imm) else $error("immediate subtract wrong");

	property p_borrow_clears;
		i_valid && i_op == rrsb_pkg::OP_SUBTRACT_WITH_BORROW_MEM
			&& ({1'b0, work_register} < {1'b0, i_mem_data} + {{W{1'b0}}, ~flags.carry_flag})
			|=> !o_flags.carry_flag;
	endproperty
	a_borrow_clears: assert property (p_borrow_clears) else $error("carry not cleared");

	property p_noborrow_sets;
		i_valid && i_op == rrsb_pkg::OP_SUBTRACT_WITH_BORROW_MEM
			&& ({1'b0, work_register} >= {1'b0, i_mem_data} + {{W{1'b0}}, ~flags.carry_flag})
			|=> o_flags.carry_flag;
	endproperty
	a_noborrow_sets: assert property (p_noborrow_sets) else $error("carry not set");

	property p_sub_flags;
		s_req(rrsb_pkg::OP_SUBTRACT_WITH_BORROW_MEM) |=>
			o_flags.zero_flag == (o_work_register == '0)
			&& o_flags.extended_sign_flag
				== (o_work_register[W-1] ^ o_flags.signed_wrap_flag)
			&& o_flags.chained_null_flag == (o_flags.zero_flag && h_flags.chained_null_flag);
	endproperty
	a_sub_flags: assert property (p_sub_flags) else $error("subtract flags wrong");

	property p_sub_arith;
		s_sub |=> o_work_register == h_diff[W-1:0]
			&& o_flags.carry_flag == !h_diff[W]
			&& o_flags.half_carry_flag == !h_low[NW]
			&& o_flags.signed_wrap_flag == ((h_work[W-1] != h_src[W-1])
				&& (h_diff[W-1] != h_work[W-1]));
	endproperty
	a_sub_arith: assert property (p_sub_arith) else $error("subtract flags off");

	property p_rotc_flags;
		s_rotc |=> o_flags.signed_wrap_flag == h_flags.signed_wrap_flag
			&& o_flags.zero_flag == h_flags.zero_flag
			&& o_flags.half_carry_flag == h_flags.half_carry_flag
			&& o_flags.extended_sign_flag == h_flags.extended_sign_flag
			&& o_flags.chained_null_flag == h_flags.chained_null_flag;
	endproperty
	a_rotc_flags: assert property (p_rotc_flags) else $error("rotate touched other flags");

	property p_mem_kept;
		!(i_valid && (i_op == rrsb_pkg::OP_ROTATE_RIGHT_MEM
			|| i_op == rrsb_pkg::OP_ROTATE_RIGHT_THRU_FLAG))
			|=> !o_mem_wr && $stable(o_mem_wr_data);
	endproperty
	a_mem_kept: assert property (p_mem_kept) else $error("memory written by wrong op");

	property p_done;
		i_valid && i_op != rrsb_pkg::OP_IDLE |=> o_done;
	endproperty
	a_done: assert property (p_done) else $error("completion strobe missing");

	property p_idle_keeps;
		!i_valid || i_op == rrsb_pkg::OP_IDLE
			|=> !o_done && o_work_register == h_work && o_flags == h_flags;
	endproperty
	a_idle_keeps: assert property (p_idle_keeps) else $error("idle cycle changed state");
endmodule

// ==== dv/rotate_right_and_subtract_borrow_bench.sv ====
// Self-checking bench for the rotate-right and subtract-with-borrow datapath
`timescale 1ns/10ps
module rotate_right_and_subtract_borrow_bench;
	typedef struct packed {
		logic [7:0]            work;
		rrsb_pkg::rrsb_flags_s flags;
		logic                  wr;
		logic [7:0]            wdata;
	} rrsb_note_s;

	logic                  i_core_clk = 1'b0;
	logic                  i_reset    = 1'b1;
	logic                  i_valid    = 1'b0;
	rrsb_pkg::rrsb_op_e    i_op       = rrsb_pkg::OP_IDLE;
	logic [7:0]            i_mem_data = 8'h00;
	logic [7:0]            i_imm      = 8'h00;
	logic                  o_mem_wr;
	logic [7:0]            o_mem_wr_data;
	logic                  o_done;
	logic [7:0]            o_work_register;
	rrsb_pkg::rrsb_flags_s o_flags;
	rrsb_note_s            notes[$];
	logic [7:0]            m_work;
	logic [7:0]            m_wdata;
	rrsb_pkg::rrsb_flags_s m_flags;
	logic [31:0]           lfsr = 32'hffec6a7b;
	int                    bad_count = 0;
	int                    total_checks = 0;

	rrsb_top dut_u (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_valid(i_valid), .i_op(i_op),
		.i_mem_data(i_mem_data), .i_imm(i_imm), .o_mem_wr(o_mem_wr),
		.o_mem_wr_data(o_mem_wr_data), .o_done(o_done), .o_work_register(o_work_register),
		.o_flags(o_flags));

	always #5 i_core_clk = ~i_core_clk;

	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
	endfunction

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("Counts: %0d checks, %0d mismatches", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic model_reset();
		m_work = 8'h00;
		m_wdata = 8'h00;
		m_flags = '0;
		notes.delete();
	endtask

	// Drives one request and notes what it must leave behind
	task automatic issue(input logic v, input logic [2:0] op, input logic [7:0] mem, imm);
		logic [8:0] d;
		logic [4:0] h;
		logic [7:0] b;
		logic [7:0] r;
		logic       ov;
		rrsb_note_s n;
		i_valid = v;
		i_op = rrsb_pkg::rrsb_op_e'(op);
		i_mem_data = mem;
		i_imm = imm;
		n.wr = 1'b0;
		if (v && op != 3'd0) begin
			case (op)
				3'd1: begin
					m_wdata = {mem[0], mem[7:1]};
					n.wr = 1'b1;
				end
				3'd2: m_work = {mem[0], mem[7:1]};
				3'd3: begin
					m_wdata = {m_flags.carry_flag, mem[7:1]};
					m_flags.carry_flag = mem[0];
					n.wr = 1'b1;
				end
				3'd4: begin
					m_work = {m_flags.carry_flag, mem[7:1]};
					m_flags.carry_flag = mem[0];
				end
				3'd5, 3'd6: begin
					b = (op == 3'd5) ? mem : imm;
					d = {1'b0, m_work} - {1'b0, b} - {8'h00, ~m_flags.carry_flag};
					h = {1'b0, m_work[3:0]} - {1'b0, b[3:0]} - {4'h0, ~m_flags.carry_flag};
					r = d[7:0];
					ov = (m_work[7] != b[7]) && (r[7] != m_work[7]);
					m_flags.signed_wrap_flag = ov;
					m_flags.zero_flag = (r == 8'h00);
					m_flags.half_carry_flag = ~h[4];
					m_flags.carry_flag = ~d[8];
					m_flags.extended_sign_flag = r[7] ^ ov;
					m_flags.chained_null_flag = (r == 8'h00) && m_flags.chained_null_flag;
					m_work = r;
				end
				default: ;
			endcase
			n.work = m_work;
			n.flags = m_flags;
			n.wdata = m_wdata;
			notes.push_back(n);
		end
		@(posedge i_core_clk) #1;
	endtask

	// Watches results and compares them with the oldest note
	always @(posedge i_core_clk) begin
		rrsb_note_s e;
		#2;
		if (!i_reset) begin
			if (o_done === 1'b1 && notes.size() > 0) begin
				e = notes.pop_front();
				check("work", o_work_register, e.work);
				check("flags", {2'b00, o_flags}, {2'b00, e.flags});
				check("mem_wr", {7'h00, o_mem_wr}, {7'h00, e.wr});
				check("mem_data", o_mem_wr_data, e.wdata);
			end else begin
				check("done", {7'h00, o_done}, 8'h00);
				check("idle_wr", {7'h00, o_mem_wr}, 8'h00);
			end
		end
	end

	initial begin
		repeat (5000) @(posedge i_core_clk);
		bad_count++;
		test_done();
	end

	initial begin
		model_reset();
		repeat (6) @(posedge i_core_clk);
		#1 i_reset = 1'b0;
		@(posedge i_core_clk) #1;
		// Back-to-back walk through every operation code
		issue(1'b1, 3'd4, 8'h01, 8'h00);
		issue(1'b1, 3'd2, 8'h0a, 8'h00);
		issue(1'b1, 3'd5, 8'h07, 8'h00);
		issue(1'b1, 3'd6, 8'h00, 8'h80);
		issue(1'b1, 3'd3, 8'h01, 8'h00);
		issue(1'b1, 3'd1, 8'h01, 8'h00);
		issue(1'b1, 3'd7, 8'hff, 8'hff);
		issue(1'b1, 3'd0, 8'h55, 8'h55);
		issue(1'b1, 3'd6, 8'h00, 8'h00);
		issue(1'b0, 3'd0, 8'h00, 8'h00);
		$display("Directed sequence finished");
		for (int i = 0; i < 400; i++) begin
			lfsr = lfsr_next(lfsr);
			issue(lfsr[31:28] != 4'h0, lfsr[2:0], lfsr[15:8], lfsr[23:16]);
		end
		issue(1'b0, 3'd0, 8'h00, 8'h00);
		issue(1'b0, 3'd0, 8'h00, 8'h00);
		$display("Random sequence finished");
		// Reset in mid-run clears the core state
		issue(1'b1, 3'd6, 8'h00, 8'h01);
		i_reset = 1'b1;
		i_valid = 1'b0;
		@(posedge i_core_clk) #1;
		check("rst_work", o_work_register, 8'h00);
		check("rst_flags", {2'b00, o_flags}, 8'h00);
		model_reset();
		i_reset = 1'b0;
		@(posedge i_core_clk) #1;
		issue(1'b1, 3'd4, 8'h03, 8'h00);
		issue(1'b1, 3'd3, 8'h02, 8'h00);
		issue(1'b0, 3'd0, 8'h00, 8'h00);
		issue(1'b0, 3'd0, 8'h00, 8'h00);
		check("pending", notes.size() == 0 ? 8'h00 : 8'h01, 8'h00);
		$display("Reset sequence finished");
		test_done();
	end
endmodule
